// ### inc/fwr_pkg.sv
// Constants, types and helpers for the flash wrap, reset and identity command block
package fwr_pkg;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_SET_WRAP    = 8'h77;
   localparam logic [7:0] OP_RST_ARM     = 8'h66;
   localparam logic [7:0] OP_RST_GO      = 8'h99;
   localparam logic [7:0] OP_DEEP_SLEEP  = 8'hB9;
   localparam logic [7:0] OP_RELEASE_ID  = 8'hAB;
   localparam logic [7:0] OP_MFR_DEV_ID  = 8'h90;
   localparam logic [7:0] OP_IDENT_READ  = 8'h9F;

   // ----------------------------------------------------------------
   // Frame layout, in bits taken after chip select falls
   // ----------------------------------------------------------------
   localparam logic [5:0] BIT_OPCODE_LAST = 6'h07;
   localparam logic [5:0] BIT_OPCODE_DONE = 6'h08;
   localparam logic [5:0] BIT_ADDR_LAST   = 6'h1F;
   localparam logic [5:0] BIT_ADDR_DONE   = 6'h20;
   localparam logic [5:0] BIT_WRAP_LAST   = 6'h27;
   localparam logic [5:0] BIT_CNT_MAX     = 6'h3F;
   localparam int         WRAP_FLD_HI     = 5;
   localparam int         WRAP_FLD_LO     = 3;

   // ----------------------------------------------------------------
   // Wrap setting {length field, disable bit}
   // ----------------------------------------------------------------
   localparam logic [2:0]  WRAP_DEFAULT   = 3'h1;
   localparam int          WRAP_DIS_POS   = 0;
   localparam logic [23:0] WRAP_BASE_LEN  = 24'h00_0008;

   // ----------------------------------------------------------------
   // Timing, 125 MHz reference clock
   // ----------------------------------------------------------------
   localparam int         CLK_PERIOD_PS     = 8000;
   localparam int         RESET_CS_HOLD_NS  = 5;
   localparam int         SLEEP_ENTRY_NS    = 3000;
   localparam int         RELEASE_WAIT_NS   = 3000;
   localparam int         RELEASE_ID_WAIT_NS = 8000;
   localparam logic [3:0] RST_HOLD_CYC =
      4'((RESET_CS_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [11:0] SLEEP_ENTRY_CYC = 12'(SLEEP_ENTRY_NS * 1000 / CLK_PERIOD_PS);
   localparam logic [11:0] RELEASE_CYC     = 12'(RELEASE_WAIT_NS * 1000 / CLK_PERIOD_PS);
   localparam logic [11:0] RELEASE_ID_CYC  = 12'(RELEASE_ID_WAIT_NS * 1000 / CLK_PERIOD_PS);
   localparam logic [11:0] CNT_ONE         = 12'h001;

   // ----------------------------------------------------------------
   // Power state
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_ACTIVE   = 4'h1,
      ST_ENTERING = 4'h2,
      ST_SLEEP    = 4'h4,
      ST_WAKING   = 4'h8
   } fwr_pwr_e;

   // Rotate the identity shifter; 16-bit patterns sit in the top bits
   function automatic logic [23:0] fwr_rotate(input logic [23:0] v, input logic len16);
      fwr_rotate = len16 ? {v[22:8], v[23], 8'h00} : {v[22:0], v[23]};
   endfunction

endpackage

// ### design/fwr_wrap_step.sv
// Next read address with optional wrap inside an aligned section
`timescale 1ns/1ps
`default_nettype none
module fwr_wrap_step
   import fwr_pkg::*;
(
   // Current address and wrap setting
   input  wire logic [23:0] addr,
   input  wire logic [2:0]  wrap,
   // Next address
   output logic      [23:0] nxt_addr
);

   logic [23:0] inc;
   logic [23:0] mask;

   // ----------------------------------------------------------------
   // Section mask from the length field
   // ----------------------------------------------------------------
   always_comb begin
      inc  = addr + 24'h00_0001;
      mask = (WRAP_BASE_LEN << wrap[2:1]) - 24'h00_0001;
      if (wrap[WRAP_DIS_POS]) begin
         nxt_addr = inc;
      end else begin
         nxt_addr = (addr & ~mask) | (inc & mask);
      end
   end

endmodule
`default_nettype wire

// ### design/fwr_cmd.sv
// Serial flash wrap, software reset, deep sleep and identity command decoder
// --------------------------------------------------------------------
// Notes on behaviour
// - Wrap setup is 77h, 24 dummies, 8 bits
// - Only wrap bits six to four kept
// - Bit four set disables; bits 6-5 length
// - Wrap setting persists until next setup or software reset
// - Wrap setup needs quad permit bit set
// - Wrap disable bit powers up set
// - Software reset restores volatile defaults
// - Software reset ignored in deep sleep
// - Reset needs 66h then 99h, runs on rise
// - Other command after arm clears arming
// - Early chip select rise cancels reset
// - B9h sleeps only if select rises at eight
// - Asleep, only release command is recognised
// - Device starts awake after power up
// - ABh then select rise starts release wait
// - ABh plus three dummies repeats device byte
// - ABh ignored while device is busy
// - 90h alternates maker/device, address picks order
// - 9Fh sends maker, type, capacity bytes
// - Wrapped reads loop inside aligned section
// - Inputs sampled on serial clock rise
// --------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module fwr_cmd
   import fwr_pkg::*;
#(
   // Identity codes, values arbitrary
   parameter logic [7:0] MFR_ID    = 8'h5A,
   parameter logic [7:0] DEV_ID    = 8'h13,
   parameter logic [7:0] MEM_TYPE  = 8'h40,
   parameter logic [7:0] CAPACITY  = 8'h15
)(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // Serial link
   input  wire logic        sclk_in,
   input  wire logic        cs_n_in,
   input  wire logic        mosi_in,
   output logic             miso_ff,
   output logic             miso_oe_n_ff,
   // Device status
   input  wire logic        busy_in,
   input  wire logic        quad_io_permit_bit,
   // Quad read address stepping
   input  wire logic [23:0] rd_start_addr,
   input  wire logic        rd_load,
   input  wire logic        rd_step,
   output logic      [23:0] rd_addr_ff,
   // Control outputs
   output logic      [2:0]  wrap_setting_bits_ff,
   output logic             deep_sleep_ff,
   output logic             soft_reset_ff
);

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        sclk_q_ff;
   logic        cs_q_ff;
   logic [5:0]  bit_cnt_ff;
   logic [31:0] in_sh_ff;
   logic [7:0]  op_ff;
   logic        op_vld_ff;
   logic        armed_ff;
   logic [3:0]  hold_cnt_ff;
   logic [23:0] out_sh_ff;
   logic        out16_ff;
   logic        drv_ff;
   fwr_pwr_e    st_ff;
   logic [11:0] cnt_ff;
   logic [23:0] nxt_rd_addr;

   logic        rise;
   logic        fall;
   logic        cs_rise;
   logic        cmd_ok;
   logic [31:0] nxt_in_sh;
   logic        at_op;
   logic        op_take;
   logic        ld_ab;
   logic        ld_mid;
   logic        ld_jedec;
   logic        wrap_ld;
   logic        dp_go;
   logic        wake_go;
   logic        sw_rst_go;

   // ----------------------------------------------------------------
   // Edge detection and decode
   // ----------------------------------------------------------------
   always_comb begin
      rise      = sclk_in & ~sclk_q_ff & ~cs_n_in;
      fall      = ~sclk_in & sclk_q_ff & ~cs_n_in;
      cs_rise   = cs_n_in & ~cs_q_ff;
      cmd_ok    = (st_ff == ST_ACTIVE);
      nxt_in_sh = {in_sh_ff[30:0], mosi_in};
      at_op     = rise && (bit_cnt_ff == BIT_OPCODE_LAST);
      op_take   = cmd_ok || ((st_ff == ST_SLEEP) && (nxt_in_sh[7:0] == OP_RELEASE_ID));
      ld_jedec  = at_op && cmd_ok && (nxt_in_sh[7:0] == OP_IDENT_READ);
      ld_ab     = rise && (bit_cnt_ff == BIT_ADDR_LAST) && op_vld_ff
                  && (op_ff == OP_RELEASE_ID) && !busy_in;
      ld_mid    = rise && (bit_cnt_ff == BIT_ADDR_LAST) && op_vld_ff && cmd_ok
                  && (op_ff == OP_MFR_DEV_ID);
      wrap_ld   = rise && (bit_cnt_ff == BIT_WRAP_LAST) && op_vld_ff && cmd_ok
                  && (op_ff == OP_SET_WRAP) && quad_io_permit_bit;
      dp_go     = cs_rise && cmd_ok && op_vld_ff && (op_ff == OP_DEEP_SLEEP)
                  && (bit_cnt_ff == BIT_OPCODE_DONE);
      wake_go   = cs_rise && (st_ff == ST_SLEEP) && op_vld_ff && !busy_in
                  && ((bit_cnt_ff == BIT_OPCODE_DONE) || (bit_cnt_ff >= BIT_ADDR_DONE));
      sw_rst_go = cs_rise && cmd_ok && op_vld_ff && armed_ff && (op_ff == OP_RST_GO)
                  && (bit_cnt_ff == BIT_OPCODE_DONE)
                  && (hold_cnt_ff >= RST_HOLD_CYC);
   end

   // ----------------------------------------------------------------
   // Input sampling and frame tracking
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_q_ff <= 1'b0;
         cs_q_ff   <= 1'b1;
      end else begin
         sclk_q_ff <= sclk_in;
         cs_q_ff   <= cs_n_in;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bit_cnt_ff <= 6'h00;
         in_sh_ff   <= 32'h0000_0000;
      end else if (cs_n_in) begin
         bit_cnt_ff <= 6'h00;
      end else if (rise) begin
         in_sh_ff <= nxt_in_sh;
         if (bit_cnt_ff != BIT_CNT_MAX) begin
            bit_cnt_ff <= bit_cnt_ff + 6'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         op_ff     <= 8'h00;
         op_vld_ff <= 1'b0;
      end else if (cs_n_in) begin
         op_vld_ff <= 1'b0;
      end else if (at_op) begin
         op_ff     <= nxt_in_sh[7:0];
         op_vld_ff <= op_take;
      end
   end

   // Cycles since the last serial clock rise, for the reset hold check
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_cnt_ff <= 4'h0;
      end else if (rise) begin
         hold_cnt_ff <= 4'h0;
      end else if (hold_cnt_ff != 4'hF) begin
         hold_cnt_ff <= hold_cnt_ff + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // Software reset arming
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         armed_ff <= 1'b0;
      end else if (sw_rst_go) begin
         armed_ff <= 1'b0;
      end else if (at_op && cmd_ok) begin
         armed_ff <= (nxt_in_sh[7:0] == OP_RST_ARM)
                     || (armed_ff && (nxt_in_sh[7:0] == OP_RST_GO));
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         soft_reset_ff <= 1'b0;
      end else begin
         soft_reset_ff <= sw_rst_go;
      end
   end

   // ----------------------------------------------------------------
   // Wrap setting
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrap_setting_bits_ff <= WRAP_DEFAULT;
      end else if (sw_rst_go) begin
         wrap_setting_bits_ff <= WRAP_DEFAULT;
      end else if (wrap_ld) begin
         wrap_setting_bits_ff <= nxt_in_sh[WRAP_FLD_HI+1:WRAP_FLD_LO+1];
      end
   end

   fwr_wrap_step u_step (
      .addr     (rd_addr_ff),
      .wrap     (wrap_setting_bits_ff),
      .nxt_addr (nxt_rd_addr)
   );

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_addr_ff <= 24'h00_0000;
      end else if (rd_load) begin
         rd_addr_ff <= rd_start_addr;
      end else if (rd_step) begin
         rd_addr_ff <= nxt_rd_addr;
      end
   end

   // ----------------------------------------------------------------
   // Power state
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff  <= ST_ACTIVE;
         cnt_ff <= 12'h000;
      end else begin
         case (st_ff)
            ST_ACTIVE: begin
               if (dp_go) begin
                  st_ff  <= ST_ENTERING;
                  cnt_ff <= SLEEP_ENTRY_CYC;
               end
            end
            ST_ENTERING: begin
               if (cnt_ff <= CNT_ONE) begin
                  st_ff <= ST_SLEEP;
               end else begin
                  cnt_ff <= cnt_ff - CNT_ONE;
               end
            end
            ST_SLEEP: begin
               if (wake_go) begin
                  st_ff  <= ST_WAKING;
                  cnt_ff <= (bit_cnt_ff >= BIT_ADDR_DONE) ? RELEASE_ID_CYC : RELEASE_CYC;
               end
            end
            ST_WAKING: begin
               if (cnt_ff <= CNT_ONE) begin
                  st_ff <= ST_ACTIVE;
               end else begin
                  cnt_ff <= cnt_ff - CNT_ONE;
               end
            end
            default: begin
               st_ff <= ST_ACTIVE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         deep_sleep_ff <= 1'b0;
      end else begin
         deep_sleep_ff <= (st_ff == ST_SLEEP) || (st_ff == ST_WAKING);
      end
   end

   // ----------------------------------------------------------------
   // Identity shifter, MSB first on serial clock fall
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_sh_ff    <= 24'h00_0000;
         out16_ff     <= 1'b0;
         drv_ff       <= 1'b0;
         miso_ff      <= 1'b0;
         miso_oe_n_ff <= 1'b1;
      end else if (cs_n_in) begin
         drv_ff       <= 1'b0;
         miso_oe_n_ff <= 1'b1;
      end else if (ld_jedec) begin
         out_sh_ff <= {MFR_ID, MEM_TYPE, CAPACITY};
         out16_ff  <= 1'b0;
         drv_ff    <= 1'b1;
      end else if (ld_ab) begin
         out_sh_ff <= {DEV_ID, DEV_ID, DEV_ID};
         out16_ff  <= 1'b0;
         drv_ff    <= 1'b1;
      end else if (ld_mid) begin
         out_sh_ff <= nxt_in_sh[0] ? {DEV_ID, MFR_ID, 8'h00} : {MFR_ID, DEV_ID, 8'h00};
         out16_ff  <= 1'b1;
         drv_ff    <= 1'b1;
      end else if (fall && drv_ff) begin
         miso_ff      <= out_sh_ff[23];
         out_sh_ff    <= fwr_rotate(out_sh_ff, out16_ff);
         miso_oe_n_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   localparam int A_WAIT_MAX = 1000;

   default clocking a_clk @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence s_dp_cmd;
      dp_go ##1 (st_ff == ST_ENTERING);
   endsequence

   a_wrap_source: assert property ($changed(wrap_setting_bits_ff) |-> $past(wrap_ld || sw_rst_go))
      else $error("wrap setting changed without a setup or reset");
   a_wrap_reset: assert property ($rose(soft_reset_ff) |-> wrap_setting_bits_ff == WRAP_DEFAULT)
      else $error("wrap setting not restored by reset");
   a_reset_awake: assert property ($rose(soft_reset_ff) |-> $past(st_ff) == ST_ACTIVE)
      else $error("software reset while asleep");
   a_reset_hold: assert property ($rose(soft_reset_ff) |-> $past(hold_cnt_ff) >= RST_HOLD_CYC)
      else $error("software reset with short select hold");
   a_sleep_entry: assert property (s_dp_cmd |-> ##[1:A_WAIT_MAX] (st_ff == ST_SLEEP))
      else $error("deep sleep not entered in time");
   a_sleep_quiet: assert property ((st_ff == ST_SLEEP && !miso_oe_n_ff) |-> op_ff == OP_RELEASE_ID)
      else $error("output driven in sleep by another command");
   a_jedec_first: assert property (ld_jedec |=> out_sh_ff[23:16] == MFR_ID)
      else $error("identity read does not start with maker byte");
   a_mid_order: assert property (ld_mid |=> out_sh_ff[23:16] == ($past(mosi_in) ? DEV_ID : MFR_ID))
      else $error("maker/device order wrong for address");
   a_miso_msb: assert property ((fall && drv_ff && !cs_n_in) |=> miso_ff == $past(out_sh_ff[23]))
      else $error("output bit not taken from shifter top");
   a_frame_drop: assert property (cs_rise |=> (bit_cnt_ff == 6'h00) && !op_vld_ff)
      else $error("partial frame kept after select rise");

endmodule
`default_nettype wire

// ### tb/fwr_host_model.sv
// Host side serial controller model driving the command block
`timescale 1ns/1ps
`default_nettype none
module fwr_host_model (
   // Clock
   input  wire logic ref_clk,
   // Serial link
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe_n,
   // Seen the block drive its output during the last frame
   output logic      oe_seen
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      oe_seen = 1'b0;
   end

   // ----------------------------------------------------------------
   // Frame of n clocks, msb first from tx[n-1], read bits shift into rx
   // ----------------------------------------------------------------
   task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
      rx = '0;
      oe_seen = 1'b0;
      @(posedge ref_clk);
      cs_n <= 1'b0;
      for (int j = n - 1; j >= 0; j--) begin
         mosi <= tx[j];
         sclk <= 1'b0;
         repeat (4) @(posedge ref_clk);
         rx = {rx[62:0], miso};
         if (miso_oe_n !== 1'b1) begin
            oe_seen = 1'b1;
         end
         sclk <= 1'b1;
         repeat (2) @(posedge ref_clk);
      end
      // Clock stands low, then select rises well after the hold time
      sclk <= 1'b0;
      repeat (2) @(posedge ref_clk);
      cs_n <= 1'b1;
      mosi <= ~mosi;
      // Idle gap before any further frame
      repeat (6) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// ### tb/tb_flash_wrap_reset_id_commands.sv
// Self-checking testbench for the wrap, reset and identity command block
`timescale 1ns/1ps
`default_nettype none
module tb_flash_wrap_reset_id_commands;
   import fwr_pkg::*;

   // Identity codes for the bench, values arbitrary
   localparam logic [7:0] T_MFR = 8'hC3;
   localparam logic [7:0] T_DEV = 8'h2E;
   localparam logic [7:0] T_MEM = 8'h71;
   localparam logic [7:0] T_CAP = 8'h0B;

   logic        ref_clk;
   logic        reset_n;
   logic        sclk;
   logic        cs_n;
   logic        mosi;
   logic        miso;
   logic        miso_oe_n;
   logic        oe;
   logic        busy;
   logic        qe;
   logic [23:0] rd_start;
   logic        rd_load;
   logic        rd_step;
   logic [23:0] rd_addr;
   logic [2:0]  wrap;
   logic        deep_sleep;
   logic        soft_reset;
   logic [63:0] rx;
   int          n_fail;
   int          n_checks;
   int          n_rst;

   fwr_cmd #(.MFR_ID(T_MFR), .DEV_ID(T_DEV), .MEM_TYPE(T_MEM), .CAPACITY(T_CAP)) u_dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi),
      .miso_ff(miso), .miso_oe_n_ff(miso_oe_n), .busy_in(busy), .quad_io_permit_bit(qe),
      .rd_start_addr(rd_start), .rd_load(rd_load), .rd_step(rd_step), .rd_addr_ff(rd_addr),
      .wrap_setting_bits_ff(wrap), .deep_sleep_ff(deep_sleep), .soft_reset_ff(soft_reset));

   fwr_host_model u_host (
      .ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .miso_oe_n(miso_oe_n), .oe_seen(oe));

   always #4 ref_clk = ~ref_clk;

   // Count executed software resets
   always @(posedge ref_clk) begin
      if (soft_reset === 1'b1) begin
         n_rst++;
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_sleep(input logic lvl);
      int i;
      i = 0;
      while (deep_sleep !== lvl && i < 1200) begin
         @(posedge ref_clk);
         i++;
      end
      if (i >= 1200) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, deep_sleep, lvl);
         test_done();
      end
   endtask

   task automatic cmd8(input logic [7:0] op);
      u_host.xfer(64'(op), 8, rx);
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic addr_step(input logic [23:0] start);
      @(posedge ref_clk);
      rd_start <= start;
      rd_load <= 1'b1;
      @(posedge ref_clk);
      rd_load <= 1'b0;
      rd_step <= 1'b1;
      @(posedge ref_clk);
      rd_step <= 1'b0;
      @(posedge ref_clk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_power_up();
      chk(64'(wrap), 64'(3'h1));
      chk(64'(deep_sleep), 64'(1'b0));
      chk(64'({miso_oe_n, soft_reset}), 64'(2'h2));
   endtask

   task automatic t_ident();
      u_host.xfer(64'(OP_IDENT_READ) << 40, 48, rx);
      chk(64'(rx[39:0]), 64'({T_MFR, T_MEM, T_CAP, T_MFR, T_MEM}));
      for (int a = 0; a < 2; a++) begin
         u_host.xfer({OP_MFR_DEV_ID, 23'h0, a[0], 32'h0}, 64, rx);
         chk(64'(rx[31:0]), a ? 64'({T_DEV, T_MFR, T_DEV, T_MFR})
                              : 64'({T_MFR, T_DEV, T_MFR, T_DEV}));
      end
      u_host.xfer(64'(OP_RELEASE_ID) << 48, 56, rx);
      chk(64'(rx[23:0]), 64'({T_DEV, T_DEV, T_DEV}));
      @(posedge ref_clk);
      busy <= 1'b1;
      u_host.xfer(64'(OP_RELEASE_ID) << 40, 48, rx);
      chk(64'(oe), 64'(1'b0));
      busy <= 1'b0;
   endtask

   task automatic t_wrap();
      logic [23:0] base;
      base = 24'h00_1200;
      qe <= 1'b0;
      u_host.xfer(64'({OP_SET_WRAP, 24'h0, 8'h0F}), 40, rx);
      chk(64'(wrap), 64'(3'h1));
      qe <= 1'b1;
      for (int len = 0; len < 4; len++) begin
         u_host.xfer(64'({OP_SET_WRAP, 24'h0, 1'b1, len[1:0], 1'b0, 4'hF}), 40, rx);
         chk(64'(wrap), 64'({len[1:0], 1'b0}));
         addr_step(base + 24'((8 << len) - 1));
         chk(64'(rd_addr), 64'(base));
      end
      u_host.xfer(64'({OP_SET_WRAP, 24'h0, 8'h70}), 40, rx);
      chk(64'(wrap), 64'(3'h7));
      addr_step(base + 24'h00_003F);
      chk(64'(rd_addr), 64'(base + 24'h00_0040));
      u_host.xfer(64'({OP_SET_WRAP, 24'h0, 8'h20}), 40, rx);
   endtask

   task automatic t_reset();
      // Device idle, so no cut operation needs reissuing
      cmd8(OP_RST_ARM);
      cmd8(8'h05);
      cmd8(OP_RST_GO);
      chk(64'(n_rst), 64'(0));
      chk(64'(wrap), 64'(3'h2));
      cmd8(OP_RST_ARM);
      u_host.xfer(64'(OP_RST_GO >> 1), 7, rx);
      repeat (4) @(posedge ref_clk);
      chk(64'(n_rst), 64'(0));
      cmd8(OP_RST_GO);
      chk(64'(n_rst), 64'(1));
      chk(64'(wrap), 64'(3'h1));
   endtask

   task automatic t_sleep();
      u_host.xfer(64'(OP_DEEP_SLEEP) << 1, 9, rx);
      repeat (450) @(posedge ref_clk);
      chk(64'(deep_sleep), 64'(1'b0));
      cmd8(OP_DEEP_SLEEP);
      wait_sleep(1'b1);
      chk(64'(deep_sleep), 64'(1'b1));
      cmd8(OP_RST_ARM);
      cmd8(OP_RST_GO);
      chk(64'(n_rst), 64'(1));
      u_host.xfer(64'(OP_IDENT_READ) << 32, 40, rx);
      chk(64'(oe), 64'(1'b0));
      cmd8(OP_RELEASE_ID);
      // Select stays high through the release wait
      wait_sleep(1'b0);
      chk(64'(deep_sleep), 64'(1'b0));
      cmd8(OP_RST_ARM);
      cmd8(OP_RST_GO);
      chk(64'(n_rst), 64'(2));
      // Release with identity readout while asleep
      cmd8(OP_DEEP_SLEEP);
      wait_sleep(1'b1);
      u_host.xfer(64'(OP_RELEASE_ID) << 48, 56, rx);
      chk(64'(rx[23:0]), 64'({T_DEV, T_DEV, T_DEV}));
      repeat (450) @(posedge ref_clk);
      chk(64'(deep_sleep), 64'(1'b1));
      wait_sleep(1'b0);
      chk(64'(deep_sleep), 64'(1'b0));
   endtask

   initial begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      busy = 1'b0;
      qe = 1'b0;
      rd_start = 24'h00_0000;
      rd_load = 1'b0;
      rd_step = 1'b0;
      n_fail = 0;
      n_checks = 0;
      n_rst = 0;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      t_power_up();
      t_ident();
      t_wrap();
      t_reset();
      t_sleep();
      test_done();
   end
endmodule
`default_nettype wire
